// ===== common/isf_pkg.sv
// package of offsets, fields and timing for the interrupt status flags block
package isf_pkg;
  // register byte offsets
  localparam logic [7:0] ISF_OFF_CFG = 8'h54; // output config / status
  localparam logic [7:0] ISF_OFF_FLAGS = 8'h58; // interrupt_flag_register
  localparam logic [7:0] ISF_OFF_ENABLE = 8'h5C; // enable register
  localparam logic [7:0] ISF_OFF_GPT = 8'h60; // general_timer_count
  localparam logic [7:0] ISF_OFF_PMC = 8'h64; // power_mgmt_control
  // flag bit positions
  localparam int ISF_B_SW = 31;
  localparam int ISF_B_READY = 30;
  localparam int ISF_B_XB = 27;
  localparam int ISF_B_XA = 26;
  localparam int ISF_B_GPT = 19;
  localparam int ISF_B_PME = 17;
  localparam int ISF_B_FB = 0;
  // implemented flag and enable mask; everything else reserved
  localparam logic [31:0] ISF_IMPL_MASK = 32'hCC0A_0001;
  // latched (write-one-to-clear) subset
  localparam logic [31:0] ISF_W1C_MASK = 32'hC00A_0000;
  // config register fields
  localparam int ISF_B_OUT_EN = 8;
  localparam int ISF_B_COMB = 12;
  localparam int ISF_B_HOLD = 13;
  localparam int ISF_B_HOLD_CLR = 14;
  localparam int ISF_HOLD_LSB = 24; // hold-off interval field 31:24
  // reset values
  localparam logic [31:0] ISF_RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] ISF_GPT_RST = 16'hFFFF;
  localparam logic [15:0] ISF_GPT_MAX = 16'hFFFF;
  // timer tick: 1 us at 100 MHz
  localparam int ISF_CLK_MHZ = 100;
  localparam int ISF_TICK_NS = 1000;
  localparam int ISF_TICK_CYC = ISF_TICK_NS * ISF_CLK_MHZ / 1000;
  // hold-off unit: 10 us in ticks
  localparam int ISF_HOLD_UNIT_TICKS = 10;
  // pmc field: status 7:0, mask 15:8
  localparam int ISF_PMC_W = 8;
endpackage

// ===== rtl/isf_holdoff.sv
// hold-off interval counter gating the request pin
`timescale 1ns/1ps
`default_nettype none
module isf_holdoff #(
  parameter int UNIT_CYC = isf_pkg::ISF_TICK_CYC * isf_pkg::ISF_HOLD_UNIT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] interval,
  input wire logic restart,
  input wire logic irq_fall,
  output logic active
);
  import isf_pkg::*;
  logic [31:0] unit_q; // cycles within one unit
  logic [7:0] left_q; // units remaining
  wire unit_end = (unit_q == 32'(UNIT_CYC - 1));
  // start on restart request or when the line drops after being asserted
  wire start = restart | (irq_fall & (interval != 8'h00));
  // interval counter; a zero interval never holds off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_q <= 32'h0000_0000;
      left_q <= 8'h00;
    end else if (start) begin
      unit_q <= 32'h0000_0000;
      left_q <= interval;
    end else if (left_q != 8'h00) begin
      unit_q <= unit_end ? 32'h0000_0000 : unit_q + 32'h0000_0001;
      if (unit_end) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
  assign active = (left_q != 8'h00);
endmodule // isf_holdoff
`default_nettype wire

// ===== rtl/isf_top.sv
// interrupt status flag register with enable, hold-off and apb access
//
// Summary of operation
// (R1) status register at 0x58, 32 bits
// (R2) flags show source status, ignoring enables
// (R3) writing one clears latched flag; zero keeps
// (R4) bit 31 set by software request trigger
// (R5) bit 30 set once device accessible
// (R6) bit 27 mirrors transceiver b event
// (R7) bit 26 mirrors transceiver a event
// (R8) bit 19 set on timer wrap
// (R9) bit 17 set on power event
// (R10) power flag stays while unmasked status set
// (R11) hold-off never delays power interrupt
// (R12) bit 0 mirrors fieldbus core event
// (R13) read-only, reserved writes ignored; reserved zero
// (R14) enable bit admits matching flag to output
// (R15) combined state ignores output enable, hold-off
// (R16) output enable clear keeps pin deasserted
// (R17) hold-off keeps pins quiet; status reads one
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module isf_top #(
  parameter int UNIT_CYC = isf_pkg::ISF_TICK_CYC * isf_pkg::ISF_HOLD_UNIT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xcvr_a_event, // asynchronous level from transceiver a
  input wire logic xcvr_b_event, // asynchronous level from transceiver b
  input wire logic fieldbus_event, // asynchronous level from the core
  input wire logic [isf_pkg::ISF_PMC_W-1:0] pm_event_raw, // async pm sources
  output logic irq
);
  import isf_pkg::*;

  // synchronisers for the outside levels
  logic [1:0] sync_a_q, sync_b_q, sync_f_q;
  logic [ISF_PMC_W-1:0] pm_s1_q, pm_s2_q, pm_prev_q;
  // register state
  logic [31:0] flags_q; // latched part of interrupt_flag_register
  logic [31:0] enable_q;
  logic out_en_q;
  logic [7:0] hold_iv_q;
  logic [15:0] gpt_q; // general_timer_count
  logic gpt_run_q;
  logic [31:0] tick_q;
  logic [ISF_PMC_W-1:0] pm_sts_q, pm_mask_q; // power_mgmt_control
  logic ready_pend_q; // one-shot ready after reset
  logic irq_q;
  logic line_prev_q;
  logic hold_clr_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;

  // two-flop synchronisers, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
      sync_f_q <= 2'h0;
      pm_s1_q <= '0;
      pm_s2_q <= '0;
    end else begin
      sync_a_q <= {sync_a_q[0], xcvr_a_event};
      sync_b_q <= {sync_b_q[0], xcvr_b_event};
      sync_f_q <= {sync_f_q[0], fieldbus_event};
      pm_s1_q <= pm_event_raw;
      pm_s2_q <= pm_s1_q;
    end
  end

  // apb decode; one wait-free access phase
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_cfg = (paddr == ISF_OFF_CFG);
  wire hit_flags = (paddr == ISF_OFF_FLAGS); // R1
  wire hit_en = (paddr == ISF_OFF_ENABLE);
  wire hit_gpt = (paddr == ISF_OFF_GPT);
  wire hit_pmc = (paddr == ISF_OFF_PMC);
  wire hit_any = hit_cfg | hit_flags | hit_en | hit_gpt | hit_pmc;
  wire wr_flags = wr & hit_flags;
  wire wr_en = wr & hit_en;
  wire wr_cfg = wr & hit_cfg;
  wire wr_gpt = wr & hit_gpt;
  wire wr_pmc = wr & hit_pmc;

  // timer tick and wrap
  wire tick = (tick_q == 32'(ISF_TICK_CYC - 1));
  wire gpt_wrap = gpt_run_q & tick & (gpt_q == 16'h0000); // R8

  // power event: rising edge of an unmasked synchronised source
  wire [ISF_PMC_W-1:0] pm_rise = pm_s2_q & ~pm_prev_q;
  wire pm_unmasked = |(pm_sts_q & pm_mask_q); // R10
  wire pm_set = |(pm_rise & pm_mask_q); // R9

  // set terms per latched flag
  logic [31:0] set_v;
  logic [31:0] clr_v;
  always_comb begin
    set_v = ISF_RST_ZERO;
    set_v[ISF_B_SW] = wr_en & pwdata[ISF_B_SW] & ~enable_q[ISF_B_SW]; // R4
    set_v[ISF_B_READY] = ready_pend_q; // R5
    set_v[ISF_B_GPT] = gpt_wrap; // R8
    set_v[ISF_B_PME] = pm_set; // R9
    // only latched bits clear; power flag waits on its controls
    clr_v = wr_flags ? (pwdata & ISF_W1C_MASK) : ISF_RST_ZERO; // R3 R13
    if (pm_unmasked) begin
      clr_v[ISF_B_PME] = 1'b0; // R10
    end
  end

  // full view: latched bits plus mirrored source levels
  logic [31:0] status_v;
  always_comb begin
    status_v = flags_q & ISF_W1C_MASK; // R2
    status_v[ISF_B_XB] = sync_b_q[1]; // R6
    status_v[ISF_B_XA] = sync_a_q[1]; // R7
    status_v[ISF_B_FB] = sync_f_q[1]; // R12
  end

  // enabled flags form the combined line
  wire [31:0] active_v = status_v & enable_q & ISF_IMPL_MASK; // R14
  wire comb_line = |active_v; // R15
  wire pme_line = active_v[ISF_B_PME];
  wire hold_active;

  // hold-off counter: begins when the combined line drops, or on a hold-off restart write
  isf_holdoff #(.UNIT_CYC(UNIT_CYC)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .interval(hold_iv_q),
    .restart(hold_clr_q),
    .irq_fall(line_prev_q & ~comb_line),
    .active(hold_active)
  );

  // pin: power event bypasses hold-off, output enable gates all
  wire irq_d = out_en_q & ((comb_line & ~hold_active) | pme_line); // R11 R16 R17

  // config register readback
  logic [31:0] cfg_v;
  always_comb begin
    cfg_v = ISF_RST_ZERO;
    cfg_v[ISF_HOLD_LSB +: 8] = hold_iv_q;
    cfg_v[ISF_B_HOLD] = hold_active; // R17
    cfg_v[ISF_B_COMB] = comb_line; // R15
    cfg_v[ISF_B_OUT_EN] = out_en_q;
  end

  // read mux; reserved bits read as zero
  wire [31:0] rd_v = hit_flags ? (status_v & ISF_IMPL_MASK) : // R13
                     hit_en ? enable_q :
                     hit_cfg ? cfg_v :
                     hit_gpt ? {15'h0000, gpt_run_q, gpt_q} :
                     hit_pmc ? {16'h0000, pm_mask_q, pm_sts_q} :
                     ISF_RST_ZERO;

  // latched flags: set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= ISF_RST_ZERO;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & ISF_W1C_MASK; // R3
    end
  end

  // device-ready one-shot after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_pend_q <= 1'b1;
    end else begin
      ready_pend_q <= 1'b0; // R5
    end
  end

  // enable and output config registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= ISF_RST_ZERO;
      out_en_q <= 1'b0;
      hold_iv_q <= 8'h00;
      hold_clr_q <= 1'b0;
    end else begin
      if (wr_en) begin
        enable_q <= pwdata & ISF_IMPL_MASK; // R14
      end
      if (wr_cfg) begin
        out_en_q <= pwdata[ISF_B_OUT_EN];
        hold_iv_q <= pwdata[ISF_HOLD_LSB +: 8];
      end
      hold_clr_q <= wr_cfg & pwdata[ISF_B_HOLD_CLR]; // self-clearing
    end
  end

  // general purpose timer: counts down each tick while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 32'h0000_0000;
      gpt_q <= ISF_GPT_RST;
      gpt_run_q <= 1'b0;
    end else begin
      tick_q <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
      if (wr_gpt) begin
        gpt_q <= pwdata[15:0];
        gpt_run_q <= pwdata[16];
      end else if (gpt_run_q & tick) begin
        gpt_q <= gpt_wrap ? ISF_GPT_MAX : gpt_q - 16'h0001; // R8
      end
    end
  end

  // power control: sticky status, set wins over w1c
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_prev_q <= '0;
      pm_sts_q <= '0;
      pm_mask_q <= '0;
    end else begin
      pm_prev_q <= pm_s2_q;
      pm_sts_q <= (pm_sts_q & ~(wr_pmc ? pwdata[7:0] : 8'h00)) | pm_rise;
      if (wr_pmc) begin
        pm_mask_q <= pwdata[15:8];
      end
    end
  end

  // outputs from flops; apb answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      line_prev_q <= 1'b0;
      prdata_q <= ISF_RST_ZERO;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      line_prev_q <= comb_line;
      pready_q <= psel & ~penable;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_v : ISF_RST_ZERO;
      pslverr_q <= psel & ~penable & ~hit_any;
    end
  end

  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // checks
  property p_w1c_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_flags & pwdata[ISF_B_GPT] & ~gpt_wrap) |=> !flags_q[ISF_B_GPT];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("gpt flag not cleared"); // R3
  property p_sw_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_en & pwdata[ISF_B_SW] & ~enable_q[ISF_B_SW]) |=> flags_q[ISF_B_SW];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("sw flag not set"); // R4
  property p_ready_boot;
    @(posedge pclk) disable iff (!presetn)
      $fell(ready_pend_q) |-> flags_q[ISF_B_READY];
  endproperty
  a_ready_boot: assert property (p_ready_boot) else $error("ready missing"); // R5
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (gpt_wrap & ~wr_gpt) |=> flags_q[ISF_B_GPT] && gpt_q == ISF_GPT_MAX;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing"); // R8
  property p_pme_hold;
    @(posedge pclk) disable iff (!presetn)
      (flags_q[ISF_B_PME] & pm_unmasked) |=> flags_q[ISF_B_PME];
  endproperty
  a_pme_hold: assert property (p_pme_hold) else $error("pme cleared early"); // R10
  property p_pme_pass;
    @(posedge pclk) disable iff (!presetn)
      (out_en_q & pme_line) |=> irq;
  endproperty
  a_pme_pass: assert property (p_pme_pass) else $error("pme held off"); // R11
  property p_out_off;
    @(posedge pclk) disable iff (!presetn)
      !out_en_q |=> !irq;
  endproperty
  a_out_off: assert property (p_out_off) else $error("irq while disabled"); // R16
  property p_hold_quiet;
    @(posedge pclk) disable iff (!presetn)
      (hold_active & !pme_line) |=> !irq;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("irq in hold-off"); // R17
  property p_mirror;
    @(posedge pclk) disable iff (!presetn)
      $rose(sync_a_q[1]) |-> status_v[ISF_B_XA];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror wrong"); // R7
endmodule // isf_top
`default_nettype wire

// ===== sim/interrupt_status_flags_tb_top.sv
// self-checking bench for the interrupt status flag block over apb
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_flags_tb_top;
  import isf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite; // bus and clocking
  logic [7:0] paddr; // byte address
  logic [31:0] pwdata, prdata, rdv; // data and last read value
  logic pready, pslverr, erv, irq; // answers
  logic xa, xb, fb; // source levels
  logic [ISF_PMC_W-1:0] pm; // power event sources
  int errors = 0; // mismatch count
  int checked = 0; // comparison count

  // short hold-off unit keeps the interval test brief
  isf_top #(.UNIT_CYC(4)) isf_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xcvr_a_event(xa), .xcvr_b_event(xb), .fieldbus_event(fb),
    .pm_event_raw(pm), .irq(irq));

  // 100 mhz clock
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; only the watchdog ends a transfer that never answers
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    rdv = rdv & m;
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  // main sequence
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; xa = 0; xb = 0; fb = 0; pm = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // ready flag after reset, zeros written keep it, ones clear
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h4000_0000);
    wr(ISF_OFF_FLAGS, 32'h0); rd(ISF_OFF_FLAGS, '1);
    chk(rdv, 32'h4000_0000);
    wr(ISF_OFF_FLAGS, 32'hFFFF_FFFF); rd(ISF_OFF_FLAGS, '1);
    chk(rdv, 32'h0);
    apb(1'b0, 8'h70, 32'h0);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    $display("test reset done");
    // enable write: reserved bits dropped, software flag raised
    wr(ISF_OFF_ENABLE, 32'hFFFF_FFFF); rd(ISF_OFF_ENABLE, '1);
    chk(rdv, ISF_IMPL_MASK);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h8000_0000);
    wr(ISF_OFF_FLAGS, 32'h8000_0000); rd(ISF_OFF_FLAGS, '1);
    chk(rdv, 32'h0);
    wr(ISF_OFF_ENABLE, 32'h0);
    $display("test software done");
    // mirrored flags follow sources and ignore ones written
    xa <= 1; xb <= 1; fb <= 1;
    repeat (4) @(posedge pclk);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0C00_0001);
    wr(ISF_OFF_FLAGS, 32'hFFFF_FFFF); rd(ISF_OFF_FLAGS, '1);
    chk(rdv, 32'h0C00_0001);
    xa <= 0; xb <= 0; fb <= 0;
    repeat (4) @(posedge pclk);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0);
    $display("test mirror done");
    // timer from 2 wraps after three ticks
    wr(ISF_OFF_GPT, 32'h0001_0002);
    repeat (2) @(posedge pclk);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0);
    repeat (3 * ISF_TICK_CYC + 100) @(posedge pclk);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0008_0000);
    wr(ISF_OFF_GPT, 32'h0); wr(ISF_OFF_FLAGS, 32'h0008_0000);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0);
    $display("test timer done");
    // power event: flag held while unmasked status stands
    wr(ISF_OFF_PMC, 32'h0000_0100);
    pm <= 8'h01;
    repeat (4) @(posedge pclk);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0002_0000);
    wr(ISF_OFF_FLAGS, 32'h0002_0000); rd(ISF_OFF_FLAGS, '1);
    chk(rdv, 32'h0002_0000);
    wr(ISF_OFF_PMC, 32'h0000_0101); wr(ISF_OFF_FLAGS, 32'h0002_0000);
    rd(ISF_OFF_FLAGS, '1); chk(rdv, 32'h0);
    pm <= 8'h00;
    $display("test power done");
    // output gated by enable bit, combined state ignores it
    wr(ISF_OFF_ENABLE, 32'h0000_0001);
    fb <= 1;
    repeat (4) @(posedge pclk);
    rd(ISF_OFF_CFG, 32'h0000_1100); chk(rdv, 32'h0000_1000);
    chk({31'h0, irq}, 32'h0);
    wr(ISF_OFF_CFG, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    $display("test output done");
    // long hold-off silences the pin, but not the power event
    wr(ISF_OFF_CFG, 32'hFF00_4100);
    repeat (2) @(posedge pclk);
    rd(ISF_OFF_CFG, 32'h0000_3100); chk(rdv, 32'h0000_3100);
    chk({31'h0, irq}, 32'h0);
    wr(ISF_OFF_ENABLE, 32'h0002_0001);
    pm <= 8'h01;
    repeat (6) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    $display("test holdoff done");
    stop_test();
  end
endmodule // interrupt_status_flags_tb_top
`default_nettype wire
